// ### verilog/sltr_pkg.sv
package sltr_pkg;
  // clock and time figures
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int CLK_PERIOD_NS   = 4;
  localparam int LINE_MIN_PS     = 9_744_360;
  localparam int LINE_MAX_MS     = 100;
  localparam int EXP_CAP_S       = 10;
  localparam int US_NS           = 1000;
  localparam int PULSE_MAX_US    = 10_000_000;
  localparam int PULSE_MIN_US    = 1;
  // widths
  localparam int LW  = 12;  // line index and line counts
  localparam int LPW = 25;  // line period in cycles
  localparam int ECW = 32;  // exposure cycle counter
  localparam int PW  = 24;  // pulse delay and width in us
  // derived cycle counts (least rounds up, longest rounds down)
  localparam logic [LPW-1:0] LINE_MIN_CYC =
    LPW'((LINE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [LPW-1:0] LINE_MAX_CYC_DEF =
    LPW'(LINE_MAX_MS * 1_000_000 / CLK_PERIOD_NS);
  localparam logic [ECW-1:0] EXP_CAP_CYC_DEF =
    ECW'(64'(EXP_CAP_S) * 64'd1_000_000_000 / 64'(CLK_PERIOD_NS));
  localparam logic [7:0]     US_CYC    = 8'(US_NS / CLK_PERIOD_NS);
  localparam logic [PW-1:0]  PULSE_MAX = PW'(PULSE_MAX_US);
  localparam logic [PW-1:0]  PULSE_MIN = PW'(PULSE_MIN_US);
  localparam logic [LW-1:0]  GAP_LINES = 12'h00a;
  localparam logic [LW-1:0]  SENSOR_LINES = 12'h800;
  localparam logic [LW-1:0]  GRAN_MIN  = 12'h004;
  // register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LINE   = 8'h04;
  localparam logic [7:0] OFS_EXP    = 8'h08;
  localparam logic [7:0] OFS_NLINES = 8'h0c;
  localparam logic [7:0] OFS_HSUB   = 8'h10;
  localparam logic [7:0] OFS_VOFF   = 8'h14;
  localparam logic [7:0] OFS_DELAY  = 8'h18;
  localparam logic [7:0] OFS_WIDTH  = 8'h1c;
  localparam logic [7:0] OFS_PRE    = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // control field positions
  localparam int B_EN = 0, B_SEQ = 1, B_DIR = 2, B_MODE = 3;
  localparam int B_RISE = 5, B_BIN = 6, B_REF = 8, B_HOFF = 16;
  // reset values
  localparam logic [LW-1:0] EXP_RST = 12'h001;
  localparam logic [PW-1:0] WID_RST = 24'h00_0001;
  // operation modes and output references
  localparam logic [1:0] MODE_FREE = 2'h0, MODE_EDGE = 2'h1;
  localparam logic [1:0] MODE_START = 2'h2, MODE_BAD = 2'h3;
  localparam logic [1:0] REF_END = 2'h0, REF_FRAME = 2'h1;
  localparam logic [1:0] REF_LINE = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_WAIT = 3'h1, ST_PRE = 3'h3,
    ST_EXP = 3'h2, ST_READ = 3'h6, ST_GAP = 3'h7
  } sltr_state_e;
  typedef enum logic [1:0] {
    P_IDLE = 2'h0, P_DLY = 2'h1, P_HIGH = 2'h3
  } sltr_pulse_e;
  // classic wishbone request and answer
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } sltr_wb_req_s;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } sltr_wb_rsp_s;
endpackage : sltr_pkg

// ### verilog/sltr_top.sv
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module sltr_top #(
  parameter logic [24:0] LINE_MAX_CYC = sltr_pkg::LINE_MAX_CYC_DEF,
  parameter logic [31:0] EXP_CAP_CYC  = sltr_pkg::EXP_CAP_CYC_DEF
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // register bus
  input  wire sltr_pkg::sltr_wb_req_s wb_i,
  output      sltr_pkg::sltr_wb_rsp_s wb_o,
  // trigger pin side
  input  wire logic                   trig_i,
  output      logic                   trig_ready_o,
  output      logic                   timing_pulse_o,
  output      logic                   global_exp_o,
  // readout sequencing
  output      logic                   line_sync_o,
  output      logic                   frame_sync_o,
  output      logic                   read_end_o,
  output      logic [11:0]            line_a_o,
  output      logic [11:0]            line_b_o,
  output      logic                   binning_o
);
  import sltr_pkg::*;

  typedef struct packed {
    logic              enable;    // acquisition enabled
    logic              seq;       // line scan mode
    logic              dir;       // 1: bottom to top
    logic              rising;    // trigger edge select
    logic              bin;       // binning request
    logic [1:0]        mode;      // operation mode
    logic [1:0]        oref;      // pulse reference
    logic [LPW-1:0]    lp;        // line period, cycles
    logic [LW-1:0]     exp_lines; // exposure in lines
    logic [LW-1:0]     nlines;    // lines per frame
    logic [LW-1:0]     hsize;     // sub-array width
    logic [LW-1:0]     hoff;      // sub-array column offset
    logic [LW-1:0]     voff;      // sub-array line offset
    logic [PW-1:0]     dly;       // pulse delay, us
    logic [PW-1:0]     wid;       // pulse width, us
    logic [7:0]        pre;       // line syncs before exposure
    sltr_state_e       st;        // frame sequencer
    logic [LPW-1:0]    ltim;      // line period timer
    logic [LW-1:0]     lcnt;      // lines in current phase
    logic [ECW-1:0]    ecyc;      // exposure cycles elapsed
    logic [LW-1:0]     la;        // line being read
    logic [LW-1:0]     lb;        // second line, area mode
    logic              lsync;     // line sync pulse
    logic              fsync;     // frame sync pulse
    logic              rend;      // readout end pulse
    logic              gexp;      // all-lines-exposing level
    sltr_pulse_e       pst;       // pulse generator state
    logic [PW-1:0]     pcnt;      // pulse us countdown
    logic              pout;      // timing pulse level
    logic [7:0]        us_cnt;    // microsecond divider
    logic              sync1;     // trigger synchroniser
    logic              sync2;
    logic              sync3;     // edge history
    logic              ack;       // bus answer
    logic [31:0]       rdat;      // read data
  } sltr_regs_s;

  sltr_regs_s  q;
  sltr_regs_s  d;
  logic        us_tick;   // one cycle per microsecond
  logic        lt;        // last cycle of a line period
  logic        tedge;     // selected trigger edge
  logic        go;        // start a frame
  logic        ref_ev;    // pulse reference event
  logic        exp_end;   // exposure finishes this cycle
  logic        pre_on;    // pre line syncs wanted
  logic        acc;       // bus access taken
  logic [LW-1:0]  exp_eff;  // exposure limited to lines per frame
  logic [LW-1:0]  rlines;   // line periods per readout
  logic [LW-1:0]  lnext;    // lcnt plus one
  logic [LW-1:0]  ctr;      // centre line
  logic [31:0] rv;        // register read value
  logic [31:0] wv;        // merged write value

  // register read mux; unmapped words read zero
  always_comb begin
    rv = 32'h0000_0000;
    case (wb_i.adr[7:2])
      OFS_CTRL[7:2]: begin
        rv[B_EN]   = q.enable;
        rv[B_SEQ]  = q.seq;
        rv[B_DIR]  = q.dir;
        rv[B_MODE +: 2] = q.mode;
        rv[B_RISE] = q.rising;
        rv[B_BIN]  = q.bin & ~q.seq;
        rv[B_REF +: 2] = q.oref;
      end
      OFS_LINE[7:2]:   rv = 32'(q.lp);
      OFS_EXP[7:2]:    rv = 32'(q.exp_lines);
      OFS_NLINES[7:2]: rv = 32'(q.nlines);
      OFS_HSUB[7:2]:   rv = {4'h0, q.hoff, 4'h0, q.hsize};
      OFS_VOFF[7:2]:   rv = 32'(q.voff);
      OFS_DELAY[7:2]:  rv = 32'(q.dly);
      OFS_WIDTH[7:2]:  rv = 32'(q.wid);
      OFS_PRE[7:2]:    rv = 32'(q.pre);
      OFS_STATUS[7:2]: rv = {24'h00_0000, q.pout, q.st,
                             3'h0, trig_ready_o};
      default:         rv = 32'h0000_0000;
    endcase
  end

  // derived timing terms from registered state; bus terms acc and wv from wb_i
  always_comb begin
    us_tick = (q.us_cnt == US_CYC - 8'h01);
    lt      = (q.ltim == q.lp - 25'h000_0001);
    tedge   = q.rising ? (q.sync2 & ~q.sync3) : (~q.sync2 & q.sync3);
    exp_eff = (q.exp_lines < q.nlines) ? q.exp_lines : q.nlines;
    rlines  = q.seq ? q.nlines : {1'b0, q.nlines[LW-1:1]};
    lnext   = q.lcnt + 12'h001;
    ctr     = q.voff + {1'b0, q.nlines[LW-1:1]};
    pre_on  = q.seq && (q.oref == REF_LINE) && (q.pre != 8'h00);
    // the 10 s cap only bites once exp_eff line periods are that long
    exp_end = (lt && (lnext >= exp_eff)) ||
              (q.ecyc == EXP_CAP_CYC - 32'h0000_0001);
    acc     = wb_i.cyc && wb_i.stb && !q.ack;
    wv      = rv;
    for (int b = 0; b < 4; b++) begin
      if (wb_i.sel[b]) begin
        wv[8*b +: 8] = wb_i.dat[8*b +: 8];
      end
    end
  end

  // next state of the whole block
  always_comb begin
    d       = q;
    go      = 1'b0;
    d.ack   = 1'b0;
    d.lsync = 1'b0;
    d.fsync = 1'b0;
    d.rend  = 1'b0;
    // two flops before the edge detector looks at the pin
    d.sync1 = trig_i;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.us_cnt = us_tick ? 8'h00 : q.us_cnt + 8'h01;
    // bus slave: one wait state, writes land with ack
    if (acc) begin
      d.ack  = 1'b1;
      d.rdat = rv;
      if (wb_i.we) begin
        case (wb_i.adr[7:2])
          OFS_CTRL[7:2]: begin
            d.enable = wv[B_EN];
            d.seq    = wv[B_SEQ];
            d.dir    = wv[B_DIR];
            d.rising = wv[B_RISE];
            d.bin    = wv[B_BIN];
            d.oref   = (wv[B_REF +: 2] == 2'h3) ? REF_END
                                                : wv[B_REF +: 2];
            // only free, edge and start exist here
            d.mode   = (wv[B_MODE +: 2] == MODE_BAD) ? MODE_FREE
                                                     : wv[B_MODE +: 2];
          end
          OFS_LINE[7:2]:
            d.lp = (wv[LPW-1:0] < LINE_MIN_CYC) ? LINE_MIN_CYC :
                   (wv[31:0] > 32'(LINE_MAX_CYC)) ? LINE_MAX_CYC :
                   wv[LPW-1:0];
          OFS_EXP[7:2]:
            d.exp_lines = (wv[LW-1:0] == 12'h000) ? EXP_RST
                                                  : wv[LW-1:0];
          OFS_NLINES[7:2]: begin
            d.nlines = {wv[LW-1:2], 2'b00};
            if (wv[31:0] > 32'(SENSOR_LINES)) d.nlines = SENSOR_LINES;
            if (wv[LW-1:2] == 10'h000) d.nlines = GRAN_MIN;
          end
          OFS_HSUB[7:2]: begin
            d.hsize = {wv[LW-1:2], 2'b00};
            d.hoff  = {wv[B_HOFF+LW-1:B_HOFF+2], 2'b00};
          end
          OFS_VOFF[7:2]: d.voff = {wv[LW-1:2], 2'b00};
          OFS_DELAY[7:2]:
            d.dly = (wv > 32'(PULSE_MAX)) ? PULSE_MAX : wv[PW-1:0];
          OFS_WIDTH[7:2]:
            d.wid = (wv > 32'(PULSE_MAX)) ? PULSE_MAX :
                    (wv[PW-1:0] < PULSE_MIN) ? PULSE_MIN : wv[PW-1:0];
          OFS_PRE[7:2]: d.pre = wv[7:0];
          default: ;  // unmapped or read-only: acked, ignored
        endcase
      end
    end
    // line timer runs while a frame is in flight
    if (q.st == ST_IDLE || q.st == ST_WAIT) d.ltim = '0;
    else d.ltim = lt ? '0 : q.ltim + 25'h000_0001;
    // frame sequencer
    case (q.st)
      ST_IDLE: begin
        if (q.enable) begin
          if (q.mode == MODE_FREE) go = 1'b1;
          else d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // only here is a trigger consumed; elsewhere it is dropped
        if (!q.enable) d.st = ST_IDLE;
        else if (tedge) go = 1'b1;
      end
      ST_PRE: begin
        if (lt) begin
          d.lsync = 1'b1;
          d.lcnt  = lnext;
          if (lnext >= 12'(q.pre)) begin
            d.st   = ST_EXP;
            d.lcnt = '0;
          end
        end
      end
      ST_EXP: begin
        // triggers arriving now are ignored
        d.ecyc = q.ecyc + 32'h0000_0001;
        if (lt) d.lcnt = lnext;
        if (exp_end) begin
          d.st    = ST_READ;
          d.lcnt  = '0;
          d.ltim  = '0;
          d.fsync = 1'b1;
          d.lsync = 1'b1;
          if (!q.seq) begin
            d.la = ctr - 12'h001;
            d.lb = ctr;
          end else begin
            d.la = q.dir ? ctr + {1'b0, q.nlines[LW-1:1]} - 12'h001
                         : q.voff;
            d.lb = '0;
          end
        end
      end
      ST_READ: begin
        // readout lasts rlines line periods
        if (lt) begin
          d.lcnt = lnext;
          if (lnext >= rlines) begin
            d.st   = ST_GAP;
            d.lcnt = '0;
            d.rend = 1'b1;
          end else begin
            d.lsync = 1'b1;
            if (!q.seq) begin
              d.la = q.la - 12'h001;
              d.lb = q.lb + 12'h001;
            end else begin
              d.la = q.dir ? q.la - 12'h001 : q.la + 12'h001;
            end
          end
        end
      end
      ST_GAP: begin
        // ten blank lines close every frame
        if (lt) begin
          d.lcnt = lnext;
          if (lnext >= GAP_LINES) begin
            d.lcnt = '0;
            if (!q.enable) d.st = ST_IDLE;
            else if (q.mode == MODE_EDGE) d.st = ST_WAIT;
            else go = 1'b1;
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase
    if (go) begin
      d.st   = pre_on ? ST_PRE : ST_EXP;
      d.lcnt = '0;
      d.ltim = '0;
      d.ecyc = '0;
    end
    // all lines expose together only in area mode
    d.gexp = !q.seq && (d.st == ST_EXP);
    // programmable timing pulse
    case (q.oref)
      REF_END:   ref_ev = d.rend;
      REF_FRAME: ref_ev = d.fsync;
      REF_LINE:  ref_ev = d.lsync & q.seq;
      default:   ref_ev = 1'b0;
    endcase
    case (q.pst)
      P_DLY: begin
        if (us_tick) begin
          d.pcnt = q.pcnt - 24'h00_0001;
          if (q.pcnt == 24'h00_0001) begin
            d.pst  = P_HIGH;
            d.pcnt = q.wid;
          end
        end
      end
      P_HIGH: begin
        if (us_tick) begin
          d.pcnt = q.pcnt - 24'h00_0001;
          if (q.pcnt == 24'h00_0001) d.pst = P_IDLE;
        end
      end
      default: d.pst = P_IDLE;
    endcase
    // a new reference restarts the pulse and aligns the us grid;
    // widths above the line period therefore merge on line sync when dly is zero
    if (ref_ev) begin
      d.us_cnt = 8'h00;
      d.pst    = (q.dly == '0) ? P_HIGH : P_DLY;
      d.pcnt   = (q.dly == '0) ? q.wid : q.dly;
    end
    d.pout = (d.pst == P_HIGH);
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q           <= '0;
      q.lp        <= LINE_MIN_CYC;
      q.exp_lines <= EXP_RST;
      q.nlines    <= SENSOR_LINES;
      q.hsize     <= SENSOR_LINES;
      q.wid       <= WID_RST;
      q.rising    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign wb_o.ack       = q.ack;
  assign wb_o.dat       = q.rdat;
  assign trig_ready_o   = (q.st == ST_WAIT);
  assign timing_pulse_o = q.pout;
  assign global_exp_o   = q.gexp;
  assign line_sync_o    = q.lsync;
  assign frame_sync_o   = q.fsync;
  assign read_end_o     = q.rend;
  assign line_a_o       = q.la;
  assign line_b_o       = q.lb;
  assign binning_o      = q.bin & ~q.seq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_trig_ignored: assert property (
    (q.st == ST_EXP && tedge && !exp_end) |=> q.st == ST_EXP)
    else $error("trigger disturbed running exposure");
  a_ready_start: assert property (
    (trig_ready_o && tedge && q.enable) |=>
      !trig_ready_o && (q.st == ST_EXP || q.st == ST_PRE))
    else $error("accepted trigger did not start a frame");
  a_scan_down: assert property (
    (q.seq && !q.dir && q.st == ST_READ && line_sync_o &&
     !frame_sync_o) |-> line_a_o == $past(line_a_o) + 12'h001)
    else $error("top to bottom scan skipped a line");
  a_area_pair: assert property (
    (!q.seq && q.st == ST_READ) |->
      13'(line_a_o) + 13'(line_b_o) == 13'({ctr, 1'b0}) - 13'h0001)
    else $error("area readout not symmetric about centre");
  a_gran_step: assert property (
    q.nlines[1:0] == 2'b00 && q.voff[1:0] == 2'b00 &&
    q.hsize[1:0] == 2'b00 && q.hoff[1:0] == 2'b00)
    else $error("sub-array off the four step grid");
  a_mode_legal: assert property (q.mode != MODE_BAD)
    else $error("illegal operation mode held");
  a_gap_len: assert property (
    (q.st == ST_GAP && lt && lnext < GAP_LINES) |=> q.st == ST_GAP)
    else $error("blank interval shorter than ten lines");
  a_line_range: assert property (
    q.lp >= LINE_MIN_CYC && q.lp <= LINE_MAX_CYC)
    else $error("line period out of range");
  a_exp_cap: assert property (
    q.st == ST_EXP |-> q.ecyc < EXP_CAP_CYC)
    else $error("exposure ran past its cap");
  a_no_global: assert property (
    ($past(q.seq) && q.seq) |-> !global_exp_o)
    else $error("global exposure shown in line scan");
  a_pulse_rise: assert property (
    (q.pst == P_DLY && us_tick && q.pcnt == 24'h00_0001 && !ref_ev)
      |=> timing_pulse_o)
    else $error("pulse did not follow its delay");
  a_zero_delay: assert property (
    (ref_ev && q.dly == '0) |=> timing_pulse_o [*2])
    else $error("zero delay pulse late");
  a_pre_only: assert property (q.st == ST_PRE |-> pre_on)
    else $error("pre line syncs without line reference");
  a_width_hold: assert property (
    (q.pst == P_HIGH && !us_tick && !ref_ev) |=> timing_pulse_o)
    else $error("pulse ended between microsecond ticks");

  c_edge_frame: cover property (trig_ready_o && tedge);
  c_scan_up:    cover property (q.seq && q.dir && line_sync_o);
  c_frame_end:  cover property (q.st == ST_READ ##1 q.st == ST_GAP);
  c_pulse:      cover property ($rose(timing_pulse_o));
endmodule : sltr_top

// ### verif/sltr_trig_src.sv
`timescale 1ns/1ps
// external trigger source; the pin rests at the inactive level
module sltr_trig_src (
  // clock
  input  wire logic clk_i,
  // trigger pin
  output      logic trig_o
);
  initial trig_o = 1'b0;
  // one active pulse of hi cycles; rise picks the edge sense
  task automatic fire(input bit rise, input int hi);
    @(posedge clk_i);
    trig_o <= rise;
    repeat (hi) @(posedge clk_i);
    trig_o <= ~rise;
  endtask : fire
endmodule : sltr_trig_src

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sltr_pkg::*;
  // bench side of the pins
  logic         clk_i;
  logic         rst_i;
  logic         trig;
  logic         rdy, tp, gx, ls, fs, re, bin, ptp;
  logic [11:0]  la;
  logic [31:0]  q;
  sltr_wb_req_s wb_i;
  sltr_wb_rsp_s wb_o;
  // tallies gathered while frames run
  int           miscompares, n_compared, n, n2;
  int           cyc, nls, nfs, nhi, ngx, nrd, tfs, tps, tls, tcap;
  logic [11:0]  lines [$];

  // short caps keep the run brief; minimum line stays 2437 cycles
  sltr_top #(.LINE_MAX_CYC(25'h1388),
             .EXP_CAP_CYC(32'h0000_4e20)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .trig_i(trig), .trig_ready_o(rdy), .timing_pulse_o(tp),
    .global_exp_o(gx), .line_sync_o(ls), .frame_sync_o(fs),
    .read_end_o(re), .line_a_o(la), .line_b_o(), .binning_o(bin));
  sltr_trig_src u_src (.clk_i(clk_i), .trig_o(trig));

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // value compare, four-state exact
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : cmp

  // duration compare; a few cycles of pin sync latency are allowed
  task automatic near(string nm, int e, int g);
    n_compared++;
    if (g < e - 8 || g > e + 8) begin
      miscompares++;
      $display("[ERR] %s exp %0d got %0d", nm, e, g);
    end
  endtask : near

  // classic cycle: hold the request until ack is sampled high
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_i <= '{cyc:1'b1, stb:1'b1, we:we, adr:a, sel:4'hf, dat:d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_o.ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      end_sim();
    end
    q = wb_o.dat;
    wb_i <= '0;
  endtask : wb

  function automatic logic pick(int k);
    case (k)
      0: pick = rdy;
      1: pick = fs;
      2: pick = re;
      default: pick = ~rdy;
    endcase
  endfunction : pick

  task automatic clr();
    nls = 0; nfs = 0; nhi = 0; ngx = 0; nrd = 0; tcap = -1; ptp = 0;
    lines.delete();
  endtask : clr

  // run cycle by cycle until the chosen output is high (or ready is low, for k above 2), tallying outputs
  task automatic run(int k, int lim, output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
      cyc++;
      if (ls === 1'b1) begin
        nls++; tls = cyc; tcap = cyc + 10;
      end
      if (cyc == tcap) lines.push_back(la);
      if (fs === 1'b1) begin
        if (nfs == 0) tfs = cyc;
        nfs++;
      end
      if (tp === 1'b1) begin
        if (!ptp) tps = cyc;
        nhi++;
      end
      ptp = tp;
      if (gx !== 1'b0) ngx++;
      if (rdy !== 1'b0) nrd++;
    end while (pick(k) !== 1'b1 && c < lim);
    if (pick(k) !== 1'b1) begin
      miscompares++;
      $display("[ERR] wait %0d exp 1 got 0", k);
      end_sim();
    end
  endtask : run

  task automatic t_regs();
    wb(0, OFS_CTRL, 0);   cmp("ctrl", 32'h0000_0020, q);
    wb(0, OFS_NLINES, 0); cmp("lines", 32'h0000_0800, q);
    wb(0, 8'h40, 0);      cmp("unmapped", 32'h0000_0000, q);
    wb(1, OFS_CTRL, 32'h0000_0018);
    wb(0, OFS_CTRL, 0);   cmp("mode3", 32'h0000_0000, q);
    wb(1, OFS_LINE, 32'h0000_0005);
    wb(0, OFS_LINE, 0);   cmp("line", 32'h0000_0985, q);
    wb(1, OFS_WIDTH, 32'h0000_0000);
    wb(0, OFS_WIDTH, 0);  cmp("width", 32'h0000_0001, q);
    wb(1, OFS_DELAY, 32'h00ff_ffff);
    wb(0, OFS_DELAY, 0);  cmp("delay", 32'h0098_9680, q);
    wb(1, OFS_DELAY, 32'h0000_0000);
    wb(1, OFS_CTRL, 32'h0000_0040);
    @(posedge clk_i);
    cmp("bin area", 32'h1, 32'(bin));
    wb(1, OFS_CTRL, 32'h0000_0042);
    @(posedge clk_i);
    cmp("bin scan", 32'h0, 32'(bin));
    $display("test regs done");
  endtask : t_regs

  // edge mode, top down, frame-sync pulse, stray trigger in exposure
  task automatic t_edge();
    wb(1, OFS_NLINES, 32'h0000_0004);
    wb(1, OFS_EXP, 32'h0000_0001);
    wb(1, OFS_CTRL, 32'h0000_012b);
    clr();
    run(0, 50, n);
    u_src.fire(1, 1);
    run(5, 20, n);
    u_src.fire(1, 1);
    run(1, 4000, n2);
    near("exposure", 2441, n + n2 + 4);
    run(2, 12000, n);
    near("readout", 9748, n);
    cmp("syncs", 32'd4, 32'(nls));
    for (int i = 0; i < 4; i++) begin
      cmp("line", 32'(i), 32'(lines[i]));
    end
    // zero delay: the pulse rises on the same edge as frame sync
    cmp("pulse dly", 32'd0, 32'(tps - tfs));
    cmp("pulse wid", 32'd250, 32'(nhi));
    run(0, 26000, n);
    near("gap", 24370, n);
    cmp("frames", 32'd1, 32'(nfs));
    cmp("global", 32'd0, 32'(ngx));
    $display("test edge done");
  endtask : t_edge

  // free mode, bottom up, line-sync pulse with 1 us delay
  task automatic t_free();
    // leave the trigger wait first; a mode change alone stays there
    wb(1, OFS_CTRL, 32'h0000_0000);
    wb(1, OFS_DELAY, 32'h0000_0001);
    wb(1, OFS_WIDTH, 32'h0000_0002);
    wb(1, OFS_CTRL, 32'h0000_0227);
    clr();
    run(2, 20000, n);
    cmp("syncs", 32'd4, 32'(nls));
    for (int i = 0; i < 4; i++) begin
      cmp("line", 32'(3 - i), 32'(lines[i]));
    end
    cmp("pulse dly", 32'd250, 32'(tps - tls));
    cmp("pulse wid", 32'd2000, 32'(nhi));
    cmp("ready", 32'd0, 32'(nrd));
    run(1, 30000, n);
    near("next frame", 26807, n);
    wb(1, OFS_CTRL, 32'h0000_0000);
    $display("test free done");
  endtask : t_free

  // reset, then the scenarios in turn
  initial begin
    rst_i = 1'b1;
    wb_i = '0;
    cyc = 0;
    miscompares = 0;
    n_compared = 0;
    clr();
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_edge();
    t_free();
    end_sim();
  end
endmodule : tb_top
